// *** verilog/bfs_sequencer.sv ***
// Purpose: fault, power-good and current-limit sequencing for two channels
// Assumes: analog comparators and pwm phase markers drive the inputs
// Notes: all pin inputs pass a two-flop synchroniser
// Functional notes
// - Logic supply below 4 V with chip-on high forces low drive, drops good, locks out.
// - Output out of window only drops power good, gates unaffected.
// - Fault assertion drives both low-side gates high at once.
// - Under or over voltage on either channel is a fault.
// - Output fault must persist 7 us before assertion.
// - Rail or supply loss faults; chip-on low does not.
// - Chip-on toggle with good supplies clears latched fault.
// - Logic supply dead then good with chip-on high clears fault.
// - Every recovery restarts soft-start.
// - Current trip during low conduction sets the overcurrent latch.
// - Set latch holds high drive low for the next cycle.
// - High drive resumes only after a cycle without trip.
// - Omitted pulse keeps low drive high through both off periods.
// - Latch clears at start of off period after omitted pulse.
// - Current sense blanked 150 ns after low drive rises.
// - Overcurrent enables soft-start discharge, released when it ends.
// - Good falls after 7 us out of window, rises 20 us after ok.
// - Chip-on low turns off both drives and good within 100 ns; during a latched fault the low drives stay high.
// - Input rail loss stops switching, later latches low drive high.
`timescale 1ns/100ps
`include "bfs_params.svh"
module bfs_sequencer (
    input wire logic clk,
    input wire logic reset,
    input wire logic chip_on,
    input wire bfs_pkg::bfs_sense_type sense,
    input wire logic [1:0] current_limit_sense,
    input wire logic [1:0] pwm_on_start,
    input wire logic [1:0] pwm_off_start,
    output bfs_pkg::bfs_gate_type [1:0] gate,
    output logic power_good_flag,
    output logic fault_latched,
    output logic supply_lockout,
    output logic soft_start_restart,
    output logic [1:0] soft_start_discharge
);
    import bfs_pkg::*;

    // Two-flop synchronisers; first stage feeds only the second
    localparam int SW = $bits(bfs_sense_type) + 7;
    logic [SW-1:0] sync1_ff;
    logic [SW-1:0] sync2_ff;
    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= {chip_on, sense, current_limit_sense,
                pwm_on_start, pwm_off_start};
            sync2_ff <= sync1_ff;
        end
    end

    logic en_s;
    bfs_sense_type s;
    logic [1:0] current_limit_sense_s;
    logic [1:0] on_s;
    logic [1:0] off_s;
    assign {en_s, s, current_limit_sense_s, on_s, off_s} = sync2_ff;

    // Output window checks
    function automatic logic ch_fault(input logic under, input logic over);
        return under || over;
    endfunction

    logic out_fault_raw;
    logic out_fault_q;
    logic out_ok;
    logic out_bad_q;
    logic ok_q;
    assign out_fault_raw = ch_fault(s.ch1_under, s.ch1_over) ||
        ch_fault(s.ch2_under, s.ch2_over);
    assign out_ok = s.ch1_window_ok && s.ch2_window_ok;

    bfs_qual #(.COUNT(12'(`BFS_FAULT_QUAL_CYC))) u_fault_qual (
        .clk(clk),
        .reset(reset),
        .level(out_fault_raw && en_s),
        .qualified(out_fault_q)
    );
    bfs_qual #(.COUNT(12'(`BFS_FAULT_QUAL_CYC))) u_bad_qual (
        .clk(clk),
        .reset(reset),
        .level(!out_ok),
        .qualified(out_bad_q)
    );
    bfs_qual #(.COUNT(12'(`BFS_PG_RISE_CYC))) u_ok_qual (
        .clk(clk),
        .reset(reset),
        .level(out_ok),
        .qualified(ok_q)
    );

    // Separate run length of the raw fault, so the delay check is not
    // just the qualifier watching itself
    logic [`BFS_CNT_W-1:0] raw_run_ff;
    always_ff @(posedge clk) begin
        if (reset || !(out_fault_raw && en_s)) begin
            raw_run_ff <= '0;
        end else if (raw_run_ff != 12'hfff) begin
            raw_run_ff <= raw_run_ff + 12'h001;
        end
    end
    fault_delay_a: assert property (@(posedge clk) disable iff (reset)
        out_fault_q |-> raw_run_ff >= 12'(`BFS_FAULT_QUAL_CYC))
        else $error("fault asserted before the delay");

    // Top-level sequencer state
    bfs_state_type state_ff;
    logic en_d_ff;
    logic dead_seen_ff;
    logic supplies_ok;
    logic fault_trig;
    logic recover;
    assign supplies_ok = s.logic_supply_ok && s.input_rail_ok;
    // Supply or rail loss faults only while enabled
    assign fault_trig = out_fault_q ||
        (en_s && (!s.logic_supply_ok || !s.input_rail_ok));

    // Supply death memory for the second recovery path
    always_ff @(posedge clk) begin
        if (reset) begin
            dead_seen_ff <= 1'b0;
        end else if (state_ff != BFS_FAULT) begin
            dead_seen_ff <= 1'b0;
        end else if (s.logic_supply_dead) begin
            dead_seen_ff <= 1'b1;
        end
    end

    logic en_rise;
    assign en_rise = en_s && !en_d_ff;
    assign recover = (en_rise && supplies_ok) ||
        (dead_seen_ff && s.logic_supply_ok && en_s &&
        s.input_rail_ok);

    always_ff @(posedge clk) begin
        if (reset) begin
            en_d_ff <= 1'b0;
        end else begin
            en_d_ff <= en_s;
        end
    end

    // Sticky fault; recovery wins only with conditions gone
    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= BFS_OFF;
        end else begin
            unique case (state_ff)
                BFS_OFF: begin
                    if (en_s && supplies_ok) begin
                        state_ff <= BFS_RUN;
                    end else if (en_s && !s.logic_supply_ok) begin
                        state_ff <= BFS_FAULT;
                    end
                end
                BFS_RUN: begin
                    if (fault_trig) begin
                        state_ff <= BFS_FAULT;
                    end else if (!en_s) begin
                        state_ff <= BFS_OFF;
                    end
                end
                BFS_FAULT: begin
                    if (recover) begin
                        state_ff <= BFS_RUN;
                    end
                end
                default: begin
                    state_ff <= BFS_OFF;
                end
            endcase
        end
    end

    logic in_fault;
    logic lockout_now;
    logic running;
    assign lockout_now = !s.logic_supply_ok && en_s;
    assign in_fault = (state_ff == BFS_FAULT) || lockout_now;
    assign running = (state_ff == BFS_RUN) && !lockout_now &&
        s.input_rail_ok;

    // Soft-start restart pulse on every entry to run
    always_ff @(posedge clk) begin
        if (reset) begin
            soft_start_restart <= 1'b0;
        end else begin
            soft_start_restart <= (state_ff != BFS_RUN) && running == 1'b0
                && ((state_ff == BFS_FAULT && recover) ||
                (state_ff == BFS_OFF && en_s && supplies_ok));
        end
    end

    // Power good: qualified window, cleared by chip-on or fault
    always_ff @(posedge clk) begin
        if (reset) begin
            power_good_flag <= `BFS_POWER_GOOD_FLAG_RST;
        end else if (!en_s || in_fault || out_bad_q) begin
            power_good_flag <= 1'b0;
        end else if (ok_q && running) begin
            power_good_flag <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            fault_latched <= `BFS_FAULT_RST;
            supply_lockout <= 1'b0;
        end else begin
            fault_latched <= in_fault;
            supply_lockout <= lockout_now;
        end
    end

    // Per-channel current limit and pulse skipping
    logic [1:0] ocl_ff;
    logic [1:0] skip_ff;
    logic [1:0] hi_ff;
    logic [1:0] lo_ff;
    logic [1:0] blank_done;
    logic [1:0] trip_ff;

    for (genvar c = 0; c < 2; c++) begin : g_ch
        // Blanking after low drive rises
        bfs_qual #(.COUNT(12'(`BFS_BLANK_CYC))) u_blank (
            .clk(clk),
            .reset(reset),
            .level(lo_ff[c] && running),
            .qualified(blank_done[c])
        );

        // Overcurrent latch; trip beats clear in the same cycle
        always_ff @(posedge clk) begin
            if (reset || !running) begin
                ocl_ff[c] <= 1'b0;
            end else if (blank_done[c] && current_limit_sense_s[c]) begin
                ocl_ff[c] <= 1'b1;
            end else if (off_s[c] && skip_ff[c]) begin
                ocl_ff[c] <= 1'b0;
            end
        end

        // Remember whether this on period is skipping
        always_ff @(posedge clk) begin
            if (reset || !running) begin
                skip_ff[c] <= 1'b0;
            end else if (on_s[c]) begin
                skip_ff[c] <= ocl_ff[c];
            end else if (off_s[c]) begin
                skip_ff[c] <= 1'b0;
            end
        end

        // Gate drive phase tracking
        always_ff @(posedge clk) begin
            if (reset) begin
                hi_ff[c] <= 1'b0;
                lo_ff[c] <= 1'b0;
            end else if (in_fault) begin
                hi_ff[c] <= 1'b0;
                lo_ff[c] <= 1'b1;
            end else if (!running) begin
                hi_ff[c] <= 1'b0;
                lo_ff[c] <= 1'b0;
            end else if (on_s[c]) begin
                hi_ff[c] <= !ocl_ff[c];
                lo_ff[c] <= ocl_ff[c];
            end else if (off_s[c]) begin
                hi_ff[c] <= 1'b0;
                lo_ff[c] <= 1'b1;
            end
        end

        // Soft-start discharge while overcurrent is active
        always_ff @(posedge clk) begin
            if (reset) begin
                trip_ff[c] <= 1'b0;
            end else begin
                trip_ff[c] <= running && (ocl_ff[c] || skip_ff[c]);
            end
        end

        assign gate[c].high_side_gate_drive = hi_ff[c];
        assign gate[c].low_side_gate_drive = lo_ff[c];
        assign soft_start_discharge[c] = trip_ff[c];
    end

    // Checks
    fault_low_drive_a: assert property (@(posedge clk) disable iff (reset)
        state_ff == BFS_FAULT |=> gate[0].low_side_gate_drive)
        else $error("low drive not high under fault");
    lockout_pg_a: assert property (@(posedge clk) disable iff (reset)
        supply_lockout |-> !power_good_flag)
        else $error("power good high during lockout");
    ocl_skip_a: assert property (@(posedge clk) disable iff (reset)
        running && on_s[0] && ocl_ff[0] && !in_fault
        |=> !gate[0].high_side_gate_drive)
        else $error("high drive not skipped");
    fault_sticky_a: assert property (@(posedge clk) disable iff (reset)
        state_ff == BFS_FAULT && !recover |=> state_ff == BFS_FAULT)
        else $error("fault cleared without recovery");
    chip_off_a: assert property (@(posedge clk) disable iff (reset)
        !en_s && !in_fault |-> ##[1:2] !gate[1].high_side_gate_drive
        && !power_good_flag)
        else $error("drives not off after chip off");
    sense_blank_a: assert property (@(posedge clk) disable iff (reset)
        $rose(lo_ff[0]) |-> !blank_done[0][*8])
        else $error("sense not blanked");
    pg_rise_a: assert property (@(posedge clk) disable iff (reset)
        $rose(power_good_flag) |-> $past(ok_q))
        else $error("power good rose early");
    soft_restart_a: assert property (@(posedge clk) disable iff (reset)
        state_ff == BFS_FAULT && recover |=> soft_start_restart)
        else $error("no soft-start after recovery");
    ss_discharge_a: assert property (@(posedge clk) disable iff (reset)
        running && ocl_ff[0] |=> soft_start_discharge[0])
        else $error("no discharge during overcurrent");
    // Overcurrent latch and skip checks on the channel the tests load
    ocl_set_a: assert property (@(posedge clk) disable iff (reset)
        running && blank_done[0] && current_limit_sense_s[0] |=> ocl_ff[0])
        else $error("trip did not set the latch");
    ocl_clear_a: assert property (@(posedge clk) disable iff (reset)
        running && off_s[0] && skip_ff[0] && !(blank_done[0] && current_limit_sense_s[0])
        |=> !ocl_ff[0])
        else $error("latch not cleared after skipped pulse");
    skip_low_a: assert property (@(posedge clk) disable iff (reset)
        running && on_s[0] && ocl_ff[0] |=> gate[0].low_side_gate_drive)
        else $error("low drive dropped in skipped pulse");
    // Rail loss stops the high drives; while running, gates move only on phase markers, never on the output window
    rail_stop_a: assert property (@(posedge clk) disable iff (reset)
        en_s && !s.input_rail_ok |=> !gate[0].high_side_gate_drive
        && !gate[1].high_side_gate_drive)
        else $error("switching on without input rail");
    window_gate_a: assert property (@(posedge clk) disable iff (reset)
        running && !on_s[0] && !off_s[0] |=> $stable(gate[0]))
        else $error("gate moved without phase marker");
    fault_cov_c: cover property (@(posedge clk) state_ff == BFS_FAULT);
    recover_cov_c: cover property (@(posedge clk)
        state_ff == BFS_FAULT ##1 state_ff == BFS_RUN);
    skip_cov_c: cover property (@(posedge clk) skip_ff[0]);
    lockout_cov_c: cover property (@(posedge clk) supply_lockout);
    pg_rise_cov_c: cover property (@(posedge clk) $rose(power_good_flag));
endmodule

// *** verilog/bfs_params.svh ***
// Purpose: timing counts and reset values for the buck fault sequencer
// Assumes: 100 MHz clock, 10 ns period
// Notes: all times round up to whole clock cycles
`ifndef BFS_PARAMS_SVH
`define BFS_PARAMS_SVH
`define BFS_CLK_PERIOD_NS 10
`define BFS_FAULT_QUAL_NS 7000
`define BFS_FAULT_QUAL_CYC \
    ((`BFS_FAULT_QUAL_NS + `BFS_CLK_PERIOD_NS - 1) / `BFS_CLK_PERIOD_NS)
`define BFS_PG_RISE_NS 20000
`define BFS_PG_RISE_CYC \
    ((`BFS_PG_RISE_NS + `BFS_CLK_PERIOD_NS - 1) / `BFS_CLK_PERIOD_NS)
`define BFS_BLANK_NS 150
`define BFS_BLANK_CYC \
    ((`BFS_BLANK_NS + `BFS_CLK_PERIOD_NS - 1) / `BFS_CLK_PERIOD_NS)
`define BFS_CNT_W 12
`define BFS_FAULT_RST 1'b0
`define BFS_POWER_GOOD_FLAG_RST 1'b0
`endif

// *** verilog/bfs_pkg.sv ***
// Purpose: shared types for the buck fault sequencer
// Assumes: one clock domain
// Notes: comparator flags travel as one packed struct
package bfs_pkg;
    // Comparator and supply flags, all from analog pins
    typedef struct packed {
        logic logic_supply_ok;
        logic logic_supply_dead;
        logic input_rail_ok;
        logic ch1_under;
        logic ch1_over;
        logic ch1_window_ok;
        logic ch2_under;
        logic ch2_over;
        logic ch2_window_ok;
    } bfs_sense_type;

    // Per-channel gate drive pair
    typedef struct packed {
        logic high_side_gate_drive;
        logic low_side_gate_drive;
    } bfs_gate_type;

    typedef enum logic [1:0] {
        BFS_OFF = 2'b00,
        BFS_RUN = 2'b01,
        BFS_FAULT = 2'b11
    } bfs_state_type;
endpackage

// *** verilog/bfs_qual.sv ***
// Purpose: qualification timer, a level must hold a number of cycles
// Assumes: caller synchronises the input
// Notes: reloads whenever the level drops
`timescale 1ns/100ps
`include "bfs_params.svh"
module bfs_qual #(
    parameter logic [`BFS_CNT_W-1:0] COUNT = 12'h001
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic level,
    output logic qualified
);
    logic [`BFS_CNT_W-1:0] cnt_ff;

    // Count up while level holds, reload on drop
    always_ff @(posedge clk) begin
        if (reset || !level) begin
            cnt_ff <= '0;
        end else if (cnt_ff != COUNT) begin
            cnt_ff <= cnt_ff + 12'h001;
        end
    end

    assign qualified = level && (cnt_ff == COUNT);
endmodule

// *** bench/bfs_fet_model.sv ***
// Purpose: far side of the sequencer, phase markers and current comparator
// Assumes: one clock, phase markers come from a fixed on/off split
// Notes: channel 2 runs half a period behind, as interleaved switching does
`timescale 1ns/100ps
module bfs_fet_model #(
    parameter int HALF = 40
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [1:0] overload,
    input wire bfs_pkg::bfs_gate_type [1:0] gate,
    output logic [1:0] current_limit_sense,
    output logic [1:0] pwm_on_start,
    output logic [1:0] pwm_off_start
);
    import bfs_pkg::*;
    int phase_ff;
    // Free-running phase count over one switching period
    always_ff @(posedge clk) begin
        if (reset || phase_ff == 2 * HALF - 1) begin
            phase_ff <= 0;
        end else begin
            phase_ff <= phase_ff + 1;
        end
    end
    // On and off markers alternate, quiet during reset
    always_ff @(posedge clk) begin
        pwm_on_start <= {phase_ff == HALF - 1, phase_ff == 2 * HALF - 1}
            & {2{~reset}};
        pwm_off_start <= {phase_ff == 2 * HALF - 1, phase_ff == HALF - 1}
            & {2{~reset}};
    end
    // Sense node only goes negative while the lower switch conducts
    assign current_limit_sense = overload & {gate[1].low_side_gate_drive,
        gate[0].low_side_gate_drive};
endmodule

// *** bench/bfs_sequencer_test.sv ***
// Purpose: self-checking bench for the fault and current-limit sequencer
// Assumes: counts of 700 and 2000 cycles, three cycles of input latency
// Notes: expected levels are held in a small model and polled each cycle
`timescale 1ns/100ps
module bfs_sequencer_test;
    import bfs_pkg::*;
    localparam int QUAL = 700;
    localparam int RISE = 2000;
    logic clk, reset, chip_on, pg, fault, lock, restart;
    bfs_sense_type sense;
    logic [1:0] overload, clsense, on_st, off_st, dis;
    bfs_gate_type [1:0] gate;
    int bad_count, n_checks, len;
    logic [31:0] rng;

    bfs_sequencer dut_u (.clk(clk), .reset(reset), .chip_on(chip_on),
        .sense(sense), .current_limit_sense(clsense), .pwm_on_start(on_st),
        .pwm_off_start(off_st), .gate(gate), .power_good_flag(pg),
        .fault_latched(fault), .supply_lockout(lock),
        .soft_start_restart(restart), .soft_start_discharge(dis));
    bfs_fet_model fet_u (.clk(clk), .reset(reset), .overload(overload),
        .gate(gate), .current_limit_sense(clsense), .pwm_on_start(on_st),
        .pwm_off_start(off_st));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Index map keeps the wait tasks free of signal references
    function automatic logic probe(input int k);
        case (k)
            0: return pg;
            1: return fault;
            2: return restart;
            3: return lock;
            4: return gate[0].high_side_gate_drive;
            5: return gate[0].low_side_gate_drive;
            6: return gate[1].high_side_gate_drive;
            7: return gate[1].low_side_gate_drive;
            default: return dis[0];
        endcase
    endfunction
    task automatic complete_run();
        $display("Checks %0d, errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask
    // Bounded wait; a wait that runs out ends the run
    task automatic await(input int k, input logic v, input int lim,
        input string what);
        int i;
        for (i = 0; i < lim && probe(k) !== v; i++) begin
            cyc(1);
        end
        chk(probe(k), v, what);
        if (probe(k) !== v) begin
            complete_run();
        end
    endtask
    // Level must not move for n cycles
    task automatic hold(input int k, input logic v, input int n,
        input string what);
        int i, miss;
        miss = 0;
        for (i = 0; i < n; i++) begin
            miss += (probe(k) !== v);
            cyc(1);
        end
        chk(miss == 0, 1'b1, what);
    endtask

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    // Reference model of the sticky fault, built from the rules alone
    int m_run;
    logic m_fault, m_dead, m_on_d, m_same;
    logic m_hist[$];
    always @(negedge clk) begin
        if (reset) begin
            m_run = 0;
            m_fault = 0;
            m_dead = 0;
            m_on_d = 0;
            m_hist.delete();
        end else begin
            m_run = (chip_on && (sense.ch1_under || sense.ch1_over ||
                sense.ch2_under || sense.ch2_over)) ? m_run + 1 : 0;
            m_dead = m_dead || (m_fault && sense.logic_supply_dead);
            if (m_fault && chip_on && sense.logic_supply_ok &&
                sense.input_rail_ok && (!m_on_d || m_dead)) begin
                m_fault = 0;
                m_dead = 0;
            end else if (m_run >= QUAL || (chip_on &&
                !(sense.logic_supply_ok && sense.input_rail_ok))) begin
                m_fault = 1;
            end
            m_on_d = chip_on;
            m_hist.push_back(m_fault);
            if (m_hist.size() > 8) begin
                void'(m_hist.pop_front());
            end
            m_same = 1;
            foreach (m_hist[i]) begin
                m_same = m_same && (m_hist[i] == m_fault);
            end
            // Compare once the model has stood eight cycles, past latency
            if (m_hist.size() == 8 && m_same) begin
                n_checks++;
                if (fault !== m_fault) begin
                    bad_count++;
                    $display("Error at %0t: fault model mismatch", $time);
                end
            end
        end
    end

    initial begin
        bad_count = 0;
        n_checks = 0;
        rng = 32'h28c7;
        reset = 1;
        chip_on = 0;
        overload = 2'h0;
        sense = 9'h149;
        repeat (2) @(posedge clk);
        #1;
        reset = 0;
        chk(gate === 4'h0 && pg === 1'b0, 1'b1, "reset outputs");
        chip_on = 1;
        await(2, 1, 10, "restart on enable");
        hold(0, 0, RISE - 20, "good early");
        await(0, 1, 40, "good rise");
        // Window loss alone only drops good
        sense.ch1_window_ok = 0;
        hold(0, 1, QUAL - 20, "good fell early");
        await(0, 0, 40, "good fall");
        await(4, 1, 100, "gates held");
        chk(fault, 0, "window faulted");
        sense.ch1_window_ok = 1;
        // Two glitches each short of the delay, reload between them
        rng = xs(rng);
        len = 400 + int'(rng % 32'd200);
        sense.ch1_under = 1;
        cyc(len);
        sense.ch1_under = 0;
        cyc(5);
        sense.ch1_under = 1;
        cyc(len);
        sense.ch1_under = 0;
        hold(1, 0, QUAL + 20, "glitch faulted");
        sense.ch2_over = 1;
        hold(1, 0, QUAL - 20, "fault early");
        await(1, 1, 40, "over fault");
        chk(probe(5) & probe(7) & ~probe(4) & ~probe(6), 1, "fault gates");
        sense.ch2_over = 0;
        hold(1, 1, 100, "fault not sticky");
        chip_on = 0;
        cyc(5);
        chip_on = 1;
        await(2, 1, 10, "toggle restart");
        cyc(1);
        chk(fault, 0, "toggle clear");
        await(0, 1, RISE + 40, "good back");
        chip_on = 0;
        await(0, 0, 10, "shutdown good");
        cyc(1);
        chk(gate === 4'h0, 1, "shutdown gates");
        hold(1, 0, QUAL + 20, "enable faulted");
        chip_on = 1;
        await(2, 1, 10, "enable restart");
        sense.input_rail_ok = 0;
        await(1, 1, 10, "rail fault");
        chk(probe(5) & probe(7), 1, "rail low drive");
        sense.input_rail_ok = 1;
        hold(1, 1, 50, "rail fault cleared");
        chip_on = 0;
        cyc(5);
        chip_on = 1;
        await(2, 1, 10, "rail recovery");
        await(0, 1, RISE + 40, "good again");
        sense.logic_supply_ok = 0;
        await(3, 1, 10, "lockout");
        chk(probe(5) & probe(7) & ~pg, 1, "lockout gates");
        sense.logic_supply_dead = 1;
        cyc(5);
        sense.logic_supply_dead = 0;
        sense.logic_supply_ok = 1;
        await(2, 1, 10, "supply restart");
        cyc(1);
        chk(fault, 0, "supply clear");
        // Persistent trip on channel 1 skips every on pulse
        overload = 2'h1;
        cyc(100);
        hold(4, 0, 320, "pulse not skipped");
        hold(5, 1, 320, "low drive dropped");
        chk(dis[0], 1, "discharge");
        await(6, 1, 100, "other channel");
        overload = 2'h0;
        await(4, 1, 200, "pulse resume");
        await(8, 0, 200, "discharge end");
        complete_run();
    end
endmodule
